// File: include/exc_pkg.sv
// Package: constants and carrier types for the exception vector and priority control
// Overview of operation
// - Undefined trap when nobody can execute instruction
// - Undefined trap sets normal interrupt mask
// - Undefined return copies saved status, resumes next
// - Breakpoint behaves as a prefetch abort
// - Breakpoint taken only at execute stage
// - Abort return minus four retries breakpointed instruction
// - Halt mode breakpoint enters debug state instead
// - High vector input selects base zero or FFFF0000
// - Fixed vector offsets per exception, 0x14 unused
// - Entry mode and masks set per exception
// - Fixed priority resolves coinciding exceptions
// - Breakpoint, undefined, supervisor call mutually exclusive
// - Data abort with fast interrupt chains to fast
// - Entry saves link, status, forces mode, vectors
// - Exceptions always run in 32-bit state
// - Reset forces supervisor, both masks, clears compressed
// - Fast interrupt registered, sampled each instruction end
package exc_pkg;

	// Vector bases
	localparam logic [31:0] VEC_BASE_LOW  = 32'h0000_0000;
	localparam logic [31:0] VEC_BASE_HIGH = 32'hffff_0000;

	// Vector offsets
	localparam logic [31:0] OFS_RESET = 32'h0000_0000;
	localparam logic [31:0] OFS_UNDEF = 32'h0000_0004;
	localparam logic [31:0] OFS_SVC   = 32'h0000_0008;
	localparam logic [31:0] OFS_PABT  = 32'h0000_000c;
	localparam logic [31:0] OFS_DABT  = 32'h0000_0010;
	localparam logic [31:0] OFS_IRQ   = 32'h0000_0018;
	localparam logic [31:0] OFS_FIQ   = 32'h0000_001c;

	// Mode field codes
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;

	// Status word field positions
	localparam int STAT_T_BIT = 5;
	localparam int STAT_F_BIT = 6;
	localparam int STAT_I_BIT = 7;

	// Return address adjustments
	localparam logic [31:0] RET_ABT_SUB = 32'h0000_0004;
	localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
	localparam logic [31:0] HALF_STEP   = 32'h0000_0002;

	// Exception kinds, priority order highest first
	typedef enum logic [2:0] {
		EXC_NONE,
		EXC_RESET,
		EXC_DABT,
		EXC_FIQ,
		EXC_IRQ,
		EXC_PABT,
		EXC_UNDEF,
		EXC_SVC
	} exc_kind_t;

	// Instruction classes seen at the execute stage
	typedef struct packed {
		logic valid;
		logic is_breakpoint;
		logic is_supervisor_call;
		logic core_can_execute;
		logic coproc_accepts;
		logic prefetch_aborted;
		logic end_of_instruction;
		logic [31:0] pc;
	} exec_info_t;

	// Returned exception-entry description
	typedef struct packed {
		logic take;
		exc_kind_t kind;
		logic [31:0] vector;
		logic [4:0] mode;
		logic set_i;
		logic set_f;
		logic [31:0] link;
		logic debug_halt;
	} entry_t;

	// Handler return request
	typedef struct packed {
		logic valid;
		logic restore_status;
		logic [31:0] target;
	} exc_return_t;

endpackage

// File: src/exc_sync2.sv
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module exc_sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	input  wire logic async_in,
	output var  logic sync_out
);
	// Both stages in one state word
	typedef struct packed {
		logic meta;
		logic stable;
	} sync_state_t;

	sync_state_t st;       // Registered stages
	sync_state_t next_st;  // Next value

	// Shift the pin level through two stages
	always_comb begin
		next_st.meta   = async_in;
		next_st.stable = st.meta;
	end

	// Reset to the inactive level
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st <= '{meta: RESET_VAL, stable: RESET_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stable;
endmodule
`default_nettype wire

// File: src/exc_vector_lookup.sv
// Vector address, entry mode and mask lookup per exception kind
`timescale 1ns/1ps
`default_nettype none
module exc_vector_lookup (
	input  wire logic               high_vector_select,
	input  wire exc_pkg::exc_kind_t kind_in,
	output logic [31:0]             vector_out,
	output logic [4:0]              mode_out,
	output logic                    set_f_out
);
	logic [31:0] base;    // Selected vector base
	logic [31:0] offset;  // Offset per kind

	// Base from the configuration level
	always_comb begin
		base = high_vector_select ? exc_pkg::VEC_BASE_HIGH : exc_pkg::VEC_BASE_LOW;
	end

	// Offset, mode, fast mask per kind; 0x14 is never produced
	always_comb begin
		offset    = exc_pkg::OFS_RESET;
		mode_out  = exc_pkg::MODE_SVC;
		set_f_out = 1'b0;
		case (kind_in)
			exc_pkg::EXC_RESET: begin
				offset    = exc_pkg::OFS_RESET;
				mode_out  = exc_pkg::MODE_SVC;
				set_f_out = 1'b1;
			end
			exc_pkg::EXC_UNDEF: begin
				offset   = exc_pkg::OFS_UNDEF;
				mode_out = exc_pkg::MODE_UND;
			end
			exc_pkg::EXC_SVC: begin
				offset   = exc_pkg::OFS_SVC;
				mode_out = exc_pkg::MODE_SVC;
			end
			exc_pkg::EXC_PABT: begin
				offset   = exc_pkg::OFS_PABT;
				mode_out = exc_pkg::MODE_ABT;
			end
			exc_pkg::EXC_DABT: begin
				offset   = exc_pkg::OFS_DABT;
				mode_out = exc_pkg::MODE_ABT;
			end
			exc_pkg::EXC_IRQ: begin
				offset   = exc_pkg::OFS_IRQ;
				mode_out = exc_pkg::MODE_IRQ;
			end
			exc_pkg::EXC_FIQ: begin
				offset    = exc_pkg::OFS_FIQ;
				mode_out  = exc_pkg::MODE_FIQ;
				set_f_out = 1'b1;
			end
			default: begin
				offset = exc_pkg::OFS_RESET;
			end
		endcase
	end

	// Base and offset never overlap, so an add is exact
	assign vector_out = base + offset;
endmodule
`default_nettype wire

// File: src/exception_vector_priority_control.sv
// Exception entry, priority resolution and status-word control
`timescale 1ns/1ps
`default_nettype none
module exception_vector_priority_control (
	input  wire logic                 mclk_in,
	input  wire logic                 rst_in,
	input  wire logic                 high_vector_select_in,
	input  wire logic                 fast_interrupt_request_n_in,
	input  wire logic                 normal_interrupt_request_n_in,
	input  wire logic                 data_abort_in,
	input  wire logic                 halt_mode_in,
	input  wire exc_pkg::exec_info_t  exec_in,
	input  wire exc_pkg::exc_return_t return_in,
	output exc_pkg::entry_t           entry_out,
	output logic [31:0]               current_status_word_out,
	output logic [31:0]               saved_status_word_out,
	output logic [31:0]               undefined_mode_link_register_out,
	output logic [31:0]               abort_mode_link_register_out,
	output logic [31:0]               fetch_addr_out,
	output logic                      fetch_valid_out,
	output logic                      debug_state_out
);
	// All state of the block
	typedef struct packed {
		logic [31:0] cur_stat;     // Current status word
		logic [31:0] saved_stat;   // Saved status word of last entry
		logic [31:0] und_lr;       // Undefined mode link
		logic [31:0] abt_lr;       // Abort mode link
		logic [31:0] fetch_addr;   // Redirect target
		logic        fetch_valid;  // One-cycle redirect pulse
		logic        debug;        // Debug state entered
		logic        chain_fiq;    // Pending fast entry after data abort
		logic        after_reset;  // Reset vector fetch still owed
		exc_pkg::entry_t entry;    // Last entry description
	} state_t;

	state_t st;       // Registered state
	state_t next_st;  // Next state

	logic fiq_sync_n;  // Fast request, registered internally
	logic irq_sync_n;  // Normal request, registered internally

	// Pins cross into this clock first
	exc_sync2 #(.RESET_VAL(1'b1)) u_fiq_sync (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (fast_interrupt_request_n_in),
		.sync_out (fiq_sync_n)
	);

	exc_sync2 #(.RESET_VAL(1'b1)) u_irq_sync (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (normal_interrupt_request_n_in),
		.sync_out (irq_sync_n)
	);

	logic data_abort_s;  // Abort level from the memory side

	exc_sync2 #(.RESET_VAL(1'b0)) u_dabt_sync (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (data_abort_in),
		.sync_out (data_abort_s)
	);

	// Candidate conditions
	logic want_undef;   // Nobody can run it
	logic want_breakpoint_instruction;    // Breakpoint at execute
	logic want_svc;     // Supervisor call at execute
	logic want_pabt;    // Fetch abort reaching execute
	logic want_fiq;     // Unmasked fast request
	logic want_irq;     // Unmasked normal request
	logic at_end;       // Instruction boundary
	exc_pkg::exc_kind_t kind;  // Winner of arbitration

	// Decode of the instruction at execute; discarded ones never set valid
	always_comb begin
		at_end     = exec_in.valid && exec_in.end_of_instruction;
		// Encodings are disjoint: breakpoint wins first, then call, then undefined
		want_breakpoint_instruction  = exec_in.valid && exec_in.is_breakpoint;
		want_svc   = exec_in.valid && !exec_in.is_breakpoint
			&& exec_in.is_supervisor_call;
		want_undef = exec_in.valid && !exec_in.is_breakpoint
			&& !exec_in.is_supervisor_call
			&& !exec_in.core_can_execute && !exec_in.coproc_accepts;
		want_pabt  = exec_in.valid && exec_in.prefetch_aborted;
		// Interrupts are looked at only on instruction boundaries
		want_fiq   = at_end && !fiq_sync_n && !st.cur_stat[exc_pkg::STAT_F_BIT];
		want_irq   = at_end && !irq_sync_n && !st.cur_stat[exc_pkg::STAT_I_BIT];
	end

	// Fixed priority, highest first
	always_comb begin
		if (st.after_reset) begin
			kind = exc_pkg::EXC_RESET;
		end else if (data_abort_s) begin
			kind = exc_pkg::EXC_DABT;
		end else if (want_fiq || (st.chain_fiq && !fiq_sync_n)) begin
			kind = exc_pkg::EXC_FIQ;
		end else if (want_irq) begin
			kind = exc_pkg::EXC_IRQ;
		end else if (want_pabt || (want_breakpoint_instruction && !halt_mode_in)) begin
			kind = exc_pkg::EXC_PABT;
		end else if (want_undef) begin
			kind = exc_pkg::EXC_UNDEF;
		end else if (want_svc) begin
			kind = exc_pkg::EXC_SVC;
		end else begin
			kind = exc_pkg::EXC_NONE;
		end
	end

	logic [31:0] vec;       // Vector for the winner
	logic [4:0]  vec_mode;  // Entry mode for the winner
	logic        vec_f;     // Fast mask on entry

	exc_vector_lookup u_lookup (
		.high_vector_select (high_vector_select_in),
		.kind_in            (kind),
		.vector_out         (vec),
		.mode_out           (vec_mode),
		.set_f_out          (vec_f)
	);

	logic [31:0] next_pc;  // Address after the executing instruction

	// Return link depends on the state the instruction ran in
	always_comb begin
		next_pc = exec_in.pc + (st.cur_stat[exc_pkg::STAT_T_BIT]
			? exc_pkg::HALF_STEP : exc_pkg::WORD_STEP);
	end

	// Next state
	always_comb begin
		next_st = st;
		next_st.fetch_valid = 1'b0;
		next_st.entry.take  = 1'b0;
		// Chain chance lasts one cycle only, so a late request cannot leak past the mask
		next_st.chain_fiq   = 1'b0;
		// Halt mode turns a breakpoint into debug entry, not an abort
		if (want_breakpoint_instruction && halt_mode_in && kind == exc_pkg::EXC_NONE) begin
			next_st.debug = 1'b1;
			next_st.entry.debug_halt = 1'b1;
		end
		if (kind != exc_pkg::EXC_NONE) begin
			next_st.entry.take  = 1'b1;
			next_st.entry.kind  = kind;
			next_st.entry.vector = vec;
			next_st.entry.mode  = vec_mode;
			next_st.entry.set_i = 1'b1;
			next_st.entry.set_f = vec_f;
			next_st.entry.link  = next_pc;
			next_st.entry.debug_halt = 1'b0;
			next_st.saved_stat = st.cur_stat;
			next_st.cur_stat[4:0] = vec_mode;
			next_st.cur_stat[exc_pkg::STAT_I_BIT] = 1'b1;
			if (vec_f) begin
				next_st.cur_stat[exc_pkg::STAT_F_BIT] = 1'b1;
			end
			next_st.cur_stat[exc_pkg::STAT_T_BIT] = 1'b0;
			next_st.fetch_addr  = vec;
			next_st.fetch_valid = 1'b1;
			next_st.after_reset = 1'b0;
			// Data abort with a live unmasked fast request chains straight on
			next_st.chain_fiq = (kind == exc_pkg::EXC_DABT)
				&& !fiq_sync_n && !st.cur_stat[exc_pkg::STAT_F_BIT];
			if (kind == exc_pkg::EXC_UNDEF) begin
				next_st.und_lr = next_pc;
			end
			if (kind == exc_pkg::EXC_PABT || kind == exc_pkg::EXC_DABT) begin
				// Abort link is one step past the faulting instruction
				next_st.abt_lr = next_pc;
			end
			// Fast entry leaves the abort link alone, so a chained data abort keeps its link in the abort bank
		end else if (return_in.valid) begin
			// Handler return, status restored from the saved word
			if (return_in.restore_status) begin
				next_st.cur_stat = st.saved_stat;
			end
			if (st.cur_stat[4:0] == exc_pkg::MODE_ABT) begin
				next_st.fetch_addr = st.abt_lr - exc_pkg::RET_ABT_SUB;
			end else if (st.cur_stat[4:0] == exc_pkg::MODE_UND) begin
				next_st.fetch_addr = st.und_lr;
			end else begin
				next_st.fetch_addr = return_in.target;
			end
			next_st.fetch_valid = 1'b1;
		end
	end

	// Register everything; reset state is supervisor with both masks set
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st <= '0;
			st.cur_stat[4:0] <= exc_pkg::MODE_SVC;
			st.cur_stat[exc_pkg::STAT_I_BIT] <= 1'b1;
			st.cur_stat[exc_pkg::STAT_F_BIT] <= 1'b1;
			st.after_reset <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign entry_out                        = st.entry;
	assign current_status_word_out          = st.cur_stat;
	assign saved_status_word_out            = st.saved_stat;
	assign undefined_mode_link_register_out = st.und_lr;
	assign abort_mode_link_register_out     = st.abt_lr;
	assign fetch_addr_out                   = st.fetch_addr;
	assign fetch_valid_out                  = st.fetch_valid;
	assign debug_state_out                  = st.debug;
endmodule
`default_nettype wire

// File: dv/exc_props.sv
// Checker of exception entry, vectors and handler returns
`timescale 1ns/1ps
`default_nettype none
module exc_props (
	input wire logic                 mclk_in,
	input wire logic                 rst_in,
	input wire logic                 high_vector_select_in,
	input wire logic                 halt_mode_in,
	input wire exc_pkg::exec_info_t  exec_in,
	input wire exc_pkg::exc_return_t return_in,
	input wire exc_pkg::entry_t      entry_out,
	input wire logic [31:0]          current_status_word_out,
	input wire logic [31:0]          saved_status_word_out,
	input wire logic [31:0]          undefined_mode_link_register_out,
	input wire logic [31:0]          abort_mode_link_register_out,
	input wire logic [31:0]          fetch_addr_out,
	input wire logic                 fetch_valid_out,
	input wire logic                 debug_state_out
);
	// One clock domain, quiet while reset is high
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire                tk = entry_out.take;  // Entry pulse
	wire exc_pkg::exc_kind_t kd = entry_out.kind;  // Entry kind
	// Return only counts in a cycle with no instruction that could trap
	wire rs = return_in.valid && return_in.restore_status && !exec_in.valid;

	property p_base;
		tk |-> entry_out.vector[31:5] == ($past(high_vector_select_in) ? 27'h7fff800 : 27'h0);
	endproperty
	a_base: assert property (p_base) else $error("vector base wrong");
	property p_undef;
		tk && kd == exc_pkg::EXC_UNDEF |-> entry_out.vector[4:0] == 5'h04
			&& entry_out.mode == exc_pkg::MODE_UND && current_status_word_out[7];
	endproperty
	a_undef: assert property (p_undef) else $error("undefined entry wrong");
	property p_pabt;
		tk && kd == exc_pkg::EXC_PABT |-> entry_out.vector[4:0] == 5'h0c
			&& abort_mode_link_register_out == $past(exec_in.pc) + exc_pkg::WORD_STEP;
	endproperty
	a_pabt: assert property (p_pabt) else $error("prefetch abort entry wrong");
	property p_rst;
		$fell(rst_in) |-> ##[0:1] (tk && kd == exc_pkg::EXC_RESET
			&& current_status_word_out[7:0] == 8'hd3);
	endproperty
	a_rst: assert property (p_rst) else $error("reset entry wrong");
	property p_save;
		tk && kd != exc_pkg::EXC_RESET |-> saved_status_word_out == $past(current_status_word_out)
			&& !current_status_word_out[5];
	endproperty
	a_save: assert property (p_save) else $error("status not saved");
	property p_retabt;
		rs && current_status_word_out[4:0] == exc_pkg::MODE_ABT |=> fetch_valid_out
			&& fetch_addr_out == $past(abort_mode_link_register_out) - exc_pkg::RET_ABT_SUB
			&& current_status_word_out == $past(saved_status_word_out);
	endproperty
	a_retabt: assert property (p_retabt) else $error("abort return wrong");
	property p_retund;
		rs && current_status_word_out[4:0] == exc_pkg::MODE_UND |=> fetch_valid_out
			&& fetch_addr_out == $past(undefined_mode_link_register_out)
			&& current_status_word_out == $past(saved_status_word_out);
	endproperty
	a_retund: assert property (p_retund) else $error("undefined return wrong");
	property p_halt;
		exec_in.valid && exec_in.is_breakpoint && halt_mode_in |=> debug_state_out && !tk;
	endproperty
	a_halt: assert property (p_halt) else $error("halt breakpoint wrong");
	// Main scenarios seen
	c_undef: cover property (tk && kd == exc_pkg::EXC_UNDEF);
	c_dabt: cover property (tk && kd == exc_pkg::EXC_DABT);
	c_ret: cover property (fetch_valid_out && !tk);
endmodule
bind exception_vector_priority_control exc_props u_exc_props (
	.mclk_in, .rst_in, .high_vector_select_in, .halt_mode_in, .exec_in,
	.return_in, .entry_out, .current_status_word_out, .saved_status_word_out,
	.undefined_mode_link_register_out, .abort_mode_link_register_out,
	.fetch_addr_out, .fetch_valid_out, .debug_state_out
);
`default_nettype wire

// File: dv/exc_irq_model.sv
// Model of interrupt sources and memory abort signalling
`timescale 1ns/1ps
`default_nettype none
module exc_irq_model (
	input  wire logic mclk_in,
	input  wire logic fast_req_in,
	input  wire logic normal_req_in,
	input  wire logic abort_req_in,
	output var  logic fast_interrupt_request_n_out,
	output var  logic normal_interrupt_request_n_out,
	output var  logic data_abort_out
);
	// Lines change just after the edge, like real launch flops
	always_ff @(posedge mclk_in) begin
		fast_interrupt_request_n_out   <= ~fast_req_in;   // Active low, held
		normal_interrupt_request_n_out <= ~normal_req_in; // Active low, held
		data_abort_out                 <= abort_req_in;   // One pulse per failed access
	end
endmodule
`default_nettype wire

// File: dv/exception_vector_priority_control_tb.sv
// Self-checking bench for exception vectors, priority and returns
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; $display("FAIL %0t got %h want %h", $time, (a), (b)); end end
module exception_vector_priority_control_tb;
	// Instruction flags: valid, breakpoint_instruction, call, core, coproc, pabt, end
	localparam logic [6:0] I_OK = 7'h49;   // Plain executable
	localparam logic [6:0] I_UND = 7'h41;  // Nobody executes it
	localparam logic [6:0] I_COP = 7'h45;  // Coprocessor takes it
	localparam logic [6:0] I_BKP = 7'h69;  // Breakpoint
	localparam logic [6:0] I_SVC = 7'h59;  // Supervisor call
	localparam logic [6:0] I_GONE = 7'h29; // Breakpoint discarded
	localparam logic [6:0] I_MIX = 7'h71;  // Overlapping decode flags
	logic                 mclk_in, rst_in;  // Clock and reset
	logic                 hvs, halt;        // Vector select, halt mode
	logic                 fq, nq, aq;       // Requests to the model
	logic                 fq_n, nq_n, abt;  // Lines from the model
	exc_pkg::exec_info_t  exec_in;          // Execute stage
	exc_pkg::exc_return_t return_in;        // Handler return
	exc_pkg::entry_t      entry_out;        // Entry description
	logic [31:0]          stat, saved;      // Status words
	logic [31:0]          und_lr, abt_lr;   // Link registers
	logic [31:0]          faddr;            // Redirect address
	logic                 fvalid, dbg;      // Redirect, debug state
	int                   miscompares;      // Mismatch count
	int                   num_checks;       // Comparison count

	exception_vector_priority_control u_exception_vector_priority_control (
		.mclk_in(mclk_in), .rst_in(rst_in), .high_vector_select_in(hvs),
		.fast_interrupt_request_n_in(fq_n), .normal_interrupt_request_n_in(nq_n),
		.data_abort_in(abt), .halt_mode_in(halt), .exec_in(exec_in),
		.return_in(return_in), .entry_out(entry_out), .current_status_word_out(stat),
		.saved_status_word_out(saved), .undefined_mode_link_register_out(und_lr),
		.abort_mode_link_register_out(abt_lr), .fetch_addr_out(faddr),
		.fetch_valid_out(fvalid), .debug_state_out(dbg));
	exc_irq_model u_exc_irq_model (.mclk_in(mclk_in), .fast_req_in(fq),
		.normal_req_in(nq), .abort_req_in(aq), .fast_interrupt_request_n_out(fq_n),
		.normal_interrupt_request_n_out(nq_n), .data_abort_out(abt));

	// 40 MHz core clock
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	// One instruction for one cycle; entry shows after the next edge
	task automatic run(input logic [6:0] b, input logic [31:0] pc);
		@(posedge mclk_in);
		exec_in <= {b, pc};
		@(posedge mclk_in);
		exec_in <= '0;
		#1;
	endtask
	// Status-restoring return for one cycle
	task automatic ret();
		@(posedge mclk_in);
		return_in <= {1'b1, 1'b1, 32'h0};
		@(posedge mclk_in);
		return_in <= '0;
		#1;
	endtask
	// Entry pulse with kind, vector and mode
	task automatic ck(input exc_pkg::exc_kind_t k, input logic [31:0] v, input logic [4:0] m);
		`CHK(entry_out.take, 1'b1)
		`CHK(entry_out.kind, k)
		`CHK(entry_out.vector, v)
		`CHK(entry_out.mode, m)
		`CHK(entry_out.set_i, 1'b1)
	endtask
	// Release from reset gives the reset entry
	task automatic t_reset();
		@(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		#1;
		ck(exc_pkg::EXC_RESET, 32'h0, exc_pkg::MODE_SVC);
		`CHK(fvalid, 1'b1)
		`CHK(stat[7:0], 8'hd3)
		repeat (3) @(posedge mclk_in);
	endtask
	// Undefined trap only when nobody executes, then return
	task automatic t_undef();
		run(I_COP, 32'h100);
		`CHK(entry_out.take, 1'b0)
		run(I_UND, 32'h100);
		ck(exc_pkg::EXC_UNDEF, 32'h4, exc_pkg::MODE_UND);
		`CHK(stat[7], 1'b1)
		`CHK(und_lr, 32'h104)
		`CHK(entry_out.link, 32'h104)
		`CHK(saved[7:0], 8'hd3)
		ret();
		`CHK(faddr, 32'h104)
		`CHK(fvalid, 1'b1)
		`CHK(stat[7:0], 8'hd3)
	endtask
	// Breakpoint as prefetch abort at the high base, retry on return
	task automatic t_breakpoint_instruction();
		@(posedge mclk_in);
		hvs <= 1'b1;
		run(I_GONE, 32'h200);
		`CHK(entry_out.take, 1'b0)
		run(I_BKP, 32'h200);
		ck(exc_pkg::EXC_PABT, 32'hffff000c, exc_pkg::MODE_ABT);
		`CHK(abt_lr, 32'h204)
		ret();
		`CHK(faddr, 32'h200)
		`CHK(stat[4:0], exc_pkg::MODE_SVC)
		run(I_MIX, 32'h300);
		ck(exc_pkg::EXC_PABT, 32'hffff000c, exc_pkg::MODE_ABT);
	endtask
	// Supervisor call keeps the fast mask as it was
	task automatic t_svc();
		@(posedge mclk_in);
		hvs <= 1'b0;
		run(I_SVC, 32'h400);
		ck(exc_pkg::EXC_SVC, 32'h8, exc_pkg::MODE_SVC);
		`CHK(stat[6], 1'b1)
	endtask
	// Masked requests refused; abort beats breakpoint, no chain while masked
	task automatic t_prio();
		@(posedge mclk_in);
		fq <= 1'b1;
		nq <= 1'b1;
		repeat (4) @(posedge mclk_in);
		run(I_OK, 32'h500);
		`CHK(entry_out.take, 1'b0)
		@(posedge mclk_in);
		aq <= 1'b1;
		@(posedge mclk_in);
		aq <= 1'b0;
		@(posedge mclk_in);
		run(I_BKP, 32'h500);
		ck(exc_pkg::EXC_DABT, 32'h10, exc_pkg::MODE_ABT);
		@(posedge mclk_in);
		#1;
		`CHK(entry_out.take && entry_out.kind == exc_pkg::EXC_FIQ, 1'b0)
		fq <= 1'b0;
		nq <= 1'b0;
	endtask
	// Halt mode turns a breakpoint into debug state
	task automatic t_halt();
		@(posedge mclk_in);
		halt <= 1'b1;
		run(I_BKP, 32'h600);
		`CHK(entry_out.take, 1'b0)
		`CHK(dbg, 1'b1)
	endtask
	// Counts, verdict and end of run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence; reset high for four edges first
	initial begin
		{rst_in, hvs, halt, fq, nq, aq} = 6'h20;
		exec_in = '0;
		return_in = '0;
		miscompares = 0;
		num_checks = 0;
		repeat (3) @(posedge mclk_in);
		t_reset();
		t_undef();
		t_breakpoint_instruction();
		t_svc();
		t_prio();
		t_halt();
		print_verdict();
	end
	// Watchdog, far beyond the few dozen cycles needed
	initial begin
		repeat (5000) @(posedge mclk_in);
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
